// ### logic/rcs_control_status_page.sv
// Overview of operation
// R1 - Writing 1 to control bit 5 enters standby; clock keeps running.
// R2 - Writing 1 to control bit 4 enters power-down; clock also stops.
// R3 - Cipher flag sets only on successful second authentication step, never by write.
// R4 - Cipher flag high routes card traffic through cipher; low means plain traffic.
// R5 - Control bit 2 written 1 stops the timer; reads back 0.
// R6 - Control bit 1 written 1 starts the timer; reads back 0.
// R7 - Control bit 0 written 1 flushes FIFO, clears overflow; reads back 0.
// R8 - Control register at index 09h, resets to 00h, bits 7:6 reserved.
// R9 - Error register at index 0Ah is read-only, resets to 40h.
// R10 - Key format error clears at key load start, sets on bad key encoding.
// R11 - EEPROM rights error clears at EEPROM command start, sets on violation.
// R12 - Overflow flag sets when anyone writes into a full FIFO.
// R13 - Checksum error sets when receive checksum enabled and check fails.
// R14 - Start-of-frame error sets on wrong start-of-frame pattern.
// R15 - Parity error sets when receive parity check fails.
// R16 - Collision flag sets on bit collision; meaningful for type A only.
// R17 - Checksum, framing, parity, collision flags clear in receiver prepare state.
// R18 - Collision position at 0Bh resets 00h, holds first collision bit position.
// R19 - Collision position not updated under type B protocol.
// R20 - Timer count at 0Ch shows the live timer count.
// R21 - Timer flag rises when count decrements to zero, low while above zero.
// R22 - Host writes zero to bits 7:6, never standby and power-down together.
//
// Our own choice: the AXI4-Lite slave port.
`default_nettype none
module rcs_control_status_page
    import rcs_pkg::*;
#(
    parameter int TIMER_WIDTH = 8
) (
    // Clock and reset.
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite write channels.
    input  wire logic [RCS_ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    // AXI4-Lite read channels.
    input  wire logic [RCS_ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // Status events from the rest of the reader.
    input  wire rcs_events_t            events,
    input  wire logic                   timer_tick,
    input  wire logic [TIMER_WIDTH-1:0] timer_reload,
    // Control outputs.
    output logic                        standby_request,
    output logic                        deep_sleep_request,
    output logic                        cipher_active,
    output logic                        queue_flush_strobe,
    output logic                        timer_start_strobe,
    output logic                        timer_stop_strobe,
    output logic                        timer_running,
    output logic                        timer_irq_flag,
    output logic [TIMER_WIDTH-1:0]      timer_count
);

    // =========================================================
    // Elaboration check.
    if (TIMER_WIDTH < 1 || TIMER_WIDTH > 8) begin : g_bad_width
        $error("TIMER_WIDTH must lie between 1 and 8");
    end

    function automatic logic reg_hit(input logic [RCS_ADDR_W-1:0] addr,
                                     input logic [7:0] idx);
        reg_hit = (addr[RCS_WORD_LSB-1:0] == '0) &&
                  (8'(addr >> RCS_WORD_LSB) == idx);
    endfunction

    // =========================================================
    // Write path: address and data are held until both are in.
    logic                  aw_full;
    logic                  w_full;
    logic [RCS_ADDR_W-1:0] aw_addr;
    logic [7:0]            w_byte;
    logic                  w_lane0;

    wire wr_fire = aw_full && w_full && !s_axi_bvalid;
    wire wr_map  = reg_hit(aw_addr, RCS_IDX_CONTROL) || reg_hit(aw_addr, RCS_IDX_ERROR)
                || reg_hit(aw_addr, RCS_IDX_COLLISION) || reg_hit(aw_addr, RCS_IDX_TIMER);
    wire wr_ctl  = wr_fire && w_lane0 && reg_hit(aw_addr, RCS_IDX_CONTROL); // [R8]

    assign s_axi_awready = !aw_full;
    assign s_axi_wready  = !w_full;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full      <= 1'b0;
            w_full       <= 1'b0;
            aw_addr      <= '0;
            w_byte       <= 8'h00;
            w_lane0      <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RCS_RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_full) begin
                aw_full <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_fire) begin
                aw_full <= 1'b0;
            end
            if (s_axi_wvalid && !w_full) begin
                w_full  <= 1'b1;
                w_byte  <= s_axi_wdata[7:0];
                w_lane0 <= s_axi_wstrb[0];
            end else if (wr_fire) begin
                w_full <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_map ? RCS_RESP_OKAY : RCS_RESP_DECERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // =========================================================
    // Control register. Strobes last one cycle and are never stored.
    wire next_cipher_set = events.auth_second_step_done; // [R3]
    wire next_cipher_clr = wr_ctl && !w_byte[RCS_CTL_CIPHER];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_request    <= RCS_CTL_RESET[RCS_CTL_STANDBY];
            deep_sleep_request <= RCS_CTL_RESET[RCS_CTL_SLEEP];
            cipher_active      <= RCS_CTL_RESET[RCS_CTL_CIPHER];
            queue_flush_strobe <= 1'b0;
            timer_start_strobe <= 1'b0;
            timer_stop_strobe  <= 1'b0;
        end else begin
            if (wr_ctl) begin
                standby_request    <= w_byte[RCS_CTL_STANDBY]; // [R1]
                deep_sleep_request <= w_byte[RCS_CTL_SLEEP];   // [R2]
            end
            // A completing authentication wins over a clearing write.
            if (next_cipher_set)
                cipher_active <= 1'b1; // [R3] [R4]
            else if (next_cipher_clr)
                cipher_active <= 1'b0;
            queue_flush_strobe <= wr_ctl && w_byte[RCS_CTL_FLUSH];  // [R7]
            timer_start_strobe <= wr_ctl && w_byte[RCS_CTL_TSTART]; // [R6]
            timer_stop_strobe  <= wr_ctl && w_byte[RCS_CTL_TSTOP];  // [R5]
        end
    end

    // =========================================================
    // Error flags: each bit has a set and a clear event; set wins.
    logic [RCS_ERR_BITS-1:0] err;
    logic [RCS_ERR_BITS-1:0] err_set;
    logic [RCS_ERR_BITS-1:0] err_clr;

    assign err_set[RCS_ERR_KEY]    = events.key_format_bad;                      // [R10]
    assign err_set[RCS_ERR_RIGHTS] = events.eeprom_rights_bad;                   // [R11]
    assign err_set[RCS_ERR_OVFL]   = events.queue_write_full;                    // [R12]
    assign err_set[RCS_ERR_CRC]    = events.rx_checksum_enable && events.checksum_bad; // [R13]
    assign err_set[RCS_ERR_SOF]    = events.start_frame_bad;                     // [R14]
    assign err_set[RCS_ERR_PARITY] = events.parity_bad;                          // [R15]
    assign err_set[RCS_ERR_COLL]   = events.collision_seen;                      // [R16]

    assign err_clr[RCS_ERR_KEY]    = events.key_load_start;                      // [R10]
    assign err_clr[RCS_ERR_RIGHTS] = events.eeprom_cmd_start;                    // [R11]
    assign err_clr[RCS_ERR_OVFL]   = queue_flush_strobe;                         // [R7]
    assign err_clr[RCS_ERR_CRC]    = events.receiver_prepare_state;              // [R17]
    assign err_clr[RCS_ERR_SOF]    = events.receiver_prepare_state;
    assign err_clr[RCS_ERR_PARITY] = events.receiver_prepare_state;
    assign err_clr[RCS_ERR_COLL]   = events.receiver_prepare_state;

    for (genvar i = 0; i < RCS_ERR_BITS; i++) begin : g_err
        always_ff @(posedge aclk) begin
            if (!aresetn)
                err[i] <= RCS_ERR_RESET[i]; // [R9]
            else if (err_set[i])
                err[i] <= 1'b1;
            else if (err_clr[i])
                err[i] <= 1'b0;
        end
    end

    // =========================================================
    // Collision position: only the first collision of a frame counts.
    logic [7:0] coll_pos;
    wire coll_first = events.collision_seen && !events.protocol_type_b // [R19]
                   && (!err[RCS_ERR_COLL] || events.receiver_prepare_state);

    always_ff @(posedge aclk) begin
        if (!aresetn)
            coll_pos <= RCS_COLL_RESET;
        else if (coll_first)
            coll_pos <= events.collision_bit_pos; // [R18]
    end

    // =========================================================
    // Down-counting timer. A reload of zero ends at once with the flag up.
    wire tmr_last = timer_running && timer_tick && (timer_count == TIMER_WIDTH'(1));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_count    <= TIMER_WIDTH'(RCS_TMR_RESET);
            timer_running  <= 1'b0;
            timer_irq_flag <= 1'b0;
        end else if (timer_start_strobe) begin
            timer_count    <= timer_reload; // [R6]
            timer_running  <= timer_reload != '0;
            timer_irq_flag <= timer_reload == '0;
        end else if (timer_stop_strobe) begin
            timer_running <= 1'b0; // [R5]
        end else if (timer_running && timer_tick) begin
            timer_count <= timer_count - TIMER_WIDTH'(1); // [R20]
            if (tmr_last) begin
                timer_running  <= 1'b0;
                timer_irq_flag <= 1'b1; // [R21]
            end
        end
    end

    // =========================================================
    // Read path. Strobe bits and reserved bits read as zero.
    wire [7:0] rd_ctl = {2'b00, standby_request, deep_sleep_request,
                         cipher_active, 3'b000}; // [R5] [R6] [R7] [R8]
    wire rd_h_ctl  = reg_hit(s_axi_araddr, RCS_IDX_CONTROL);
    wire rd_h_err  = reg_hit(s_axi_araddr, RCS_IDX_ERROR);
    wire rd_h_coll = reg_hit(s_axi_araddr, RCS_IDX_COLLISION);
    wire rd_h_tmr  = reg_hit(s_axi_araddr, RCS_IDX_TIMER);
    wire rd_map    = rd_h_ctl || rd_h_err || rd_h_coll || rd_h_tmr;
    wire [7:0] rd_byte = rd_h_ctl  ? rd_ctl
                       : rd_h_err  ? {1'b0, err} // [R9]
                       : rd_h_coll ? coll_pos
                       : rd_h_tmr  ? 8'(timer_count) // [R20]
                       : 8'h00;

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RCS_RESP_OKAY;
        end else if (s_axi_arvalid && !s_axi_rvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {24'h00_0000, rd_byte};
            s_axi_rresp  <= rd_map ? RCS_RESP_OKAY : RCS_RESP_DECERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Helper for the readback check: remembers the address class of the read.
    logic rd_q_ctl;
    always_ff @(posedge aclk) begin
        if (!aresetn)
            rd_q_ctl <= 1'b0;
        else if (s_axi_arvalid && !s_axi_rvalid)
            rd_q_ctl <= rd_h_ctl;
    end

    // =========================================================
    // Assertions.
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    ctl_readback_a: assert property ( // [R8]
        s_axi_rvalid && rd_q_ctl |-> s_axi_rdata[7:6] == 2'b00 && s_axi_rdata[2:0] == 3'b000)
        else $error("control readback shows reserved or strobe bits");

    cipher_no_write_a: assert property ( // [R3]
        !cipher_active && !events.auth_second_step_done |=> !cipher_active)
        else $error("cipher flag rose without authentication");

    flush_pulse_a: assert property ( // [R7]
        wr_ctl && w_byte[RCS_CTL_FLUSH] |=> queue_flush_strobe ##1 !queue_flush_strobe)
        else $error("flush strobe not a single pulse after write");

    ovfl_flush_a: assert property ( // [R7]
        queue_flush_strobe && !events.queue_write_full |=> !err[RCS_ERR_OVFL])
        else $error("overflow flag survived a flush");

    prepare_clear_a: assert property ( // [R17]
        events.receiver_prepare_state && !events.checksum_bad && !events.start_frame_bad
        && !events.parity_bad && !events.collision_seen |=> err[RCS_ERR_CRC:RCS_ERR_COLL] == '0)
        else $error("receive error flags not cleared in prepare state");

    coll_type_b_a: assert property ( // [R19]
        events.protocol_type_b |=> $stable(coll_pos))
        else $error("collision position moved under type B");

    timer_zero_a: assert property ( // [R21]
        tmr_last && !timer_start_strobe && !timer_stop_strobe
        |=> timer_irq_flag && timer_count == '0 && !timer_running)
        else $error("timer did not flag at zero");

    timer_above_a: assert property ( // [R21]
        timer_running |-> !timer_irq_flag && timer_count != '0)
        else $error("timer flag high while count above zero");

    timer_stop_a: assert property ( // [R5]
        timer_stop_strobe && !timer_start_strobe |=> !timer_running ##1 $stable(timer_count))
        else $error("timer kept running after stop");

    key_err_a: assert property ( // [R10]
        events.key_load_start && !events.key_format_bad ##1 !events.key_format_bad
        |=> !err[RCS_ERR_KEY])
        else $error("key format flag not cleared at load start");

    // Field effects: every set, clear and pulse lands one edge after its cause.
    standby_write_a: assert property ( // [R1]
        wr_ctl |=> standby_request == $past(w_byte[RCS_CTL_STANDBY]))
        else $error("standby bit does not follow the control write");

    sleep_write_a: assert property ( // [R2]
        wr_ctl |=> deep_sleep_request == $past(w_byte[RCS_CTL_SLEEP]))
        else $error("power-down bit does not follow the control write");

    cipher_set_a: assert property ( // [R3]
        events.auth_second_step_done |=> cipher_active)
        else $error("cipher flag not set by authentication");

    cipher_clear_a: assert property ( // [R4]
        wr_ctl && !w_byte[RCS_CTL_CIPHER] && !events.auth_second_step_done |=> !cipher_active)
        else $error("cipher flag not cleared by control write");

    start_pulse_a: assert property ( // [R6]
        wr_ctl && w_byte[RCS_CTL_TSTART] |=> timer_start_strobe)
        else $error("start strobe missing after control write");

    stop_pulse_a: assert property ( // [R5]
        wr_ctl && w_byte[RCS_CTL_TSTOP] |=> timer_stop_strobe)
        else $error("stop strobe missing after control write");

    key_set_a: assert property ( // [R10]
        events.key_format_bad |=> err[RCS_ERR_KEY])
        else $error("key format flag not set");

    rights_set_a: assert property ( // [R11]
        events.eeprom_rights_bad |=> err[RCS_ERR_RIGHTS])
        else $error("access rights flag not set");

    rights_clear_a: assert property ( // [R11]
        events.eeprom_cmd_start && !events.eeprom_rights_bad |=> !err[RCS_ERR_RIGHTS])
        else $error("access rights flag not cleared at command start");

    ovfl_set_a: assert property ( // [R12]
        events.queue_write_full |=> err[RCS_ERR_OVFL])
        else $error("overflow flag not set on write into full queue");

    crc_gate_a: assert property ( // [R13]
        !events.rx_checksum_enable && !err[RCS_ERR_CRC] |=> !err[RCS_ERR_CRC])
        else $error("checksum flag set while checking is off");

    crc_set_a: assert property ( // [R13]
        events.rx_checksum_enable && events.checksum_bad |=> err[RCS_ERR_CRC])
        else $error("checksum flag not set on failed check");

    sof_set_a: assert property ( // [R14]
        events.start_frame_bad |=> err[RCS_ERR_SOF])
        else $error("start-of-frame flag not set");

    parity_set_a: assert property ( // [R15]
        events.parity_bad |=> err[RCS_ERR_PARITY])
        else $error("parity flag not set");

    coll_set_a: assert property ( // [R16]
        events.collision_seen |=> err[RCS_ERR_COLL])
        else $error("collision flag not set");

    coll_capture_a: assert property ( // [R18]
        coll_first |=> coll_pos == $past(events.collision_bit_pos))
        else $error("collision position not captured");

    timer_count_a: assert property ( // [R20]
        timer_running && timer_tick && !timer_start_strobe && !timer_stop_strobe
        |=> timer_count == $past(timer_count) - TIMER_WIDTH'(1))
        else $error("timer count did not step down on a tick");

endmodule
`default_nettype wire

// ### logic/rcs_pkg.sv
`default_nettype none
package rcs_pkg;

    // =========================================================
    // Register indices; the byte address is four times the index.
    localparam logic [7:0] RCS_IDX_CONTROL   = 8'h09;
    localparam logic [7:0] RCS_IDX_ERROR     = 8'h0A;
    localparam logic [7:0] RCS_IDX_COLLISION = 8'h0B;
    localparam logic [7:0] RCS_IDX_TIMER     = 8'h0C;
    localparam int         RCS_ADDR_W        = 8;
    localparam int         RCS_WORD_LSB      = 2;

    // =========================================================
    // Control register fields.
    localparam int RCS_CTL_STANDBY = 5;
    localparam int RCS_CTL_SLEEP   = 4;
    localparam int RCS_CTL_CIPHER  = 3;
    localparam int RCS_CTL_TSTOP   = 2;
    localparam int RCS_CTL_TSTART  = 1;
    localparam int RCS_CTL_FLUSH   = 0;

    // =========================================================
    // Error register fields and reset values.
    localparam int RCS_ERR_KEY    = 6;
    localparam int RCS_ERR_RIGHTS = 5;
    localparam int RCS_ERR_OVFL   = 4;
    localparam int RCS_ERR_CRC    = 3;
    localparam int RCS_ERR_SOF    = 2;
    localparam int RCS_ERR_PARITY = 1;
    localparam int RCS_ERR_COLL   = 0;
    localparam int RCS_ERR_BITS   = 7;

    localparam logic [7:0] RCS_CTL_RESET  = 8'h00;
    localparam logic [6:0] RCS_ERR_RESET  = 7'h40;
    localparam logic [7:0] RCS_COLL_RESET = 8'h00;
    localparam logic [7:0] RCS_TMR_RESET  = 8'h00;

    localparam logic [1:0] RCS_RESP_OKAY   = 2'h0;
    localparam logic [1:0] RCS_RESP_DECERR = 2'h3;

    // =========================================================
    // Events from the receiver, FIFO, EEPROM and key logic.
    typedef struct packed {
        logic       key_load_start;
        logic       key_format_bad;
        logic       eeprom_cmd_start;
        logic       eeprom_rights_bad;
        logic       queue_write_full;
        logic       receiver_prepare_state;
        logic       rx_checksum_enable;
        logic       checksum_bad;
        logic       start_frame_bad;
        logic       parity_bad;
        logic       collision_seen;
        logic [7:0] collision_bit_pos;
        logic       protocol_type_b;
        logic       auth_second_step_done;
    } rcs_events_t;

endpackage
`default_nettype wire

// ### verif/reader_control_status_page_bench.sv
`default_nettype none
// =========================================================
// Comparison helper.
`define CHK(got, exp) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
        end \
    end

module reader_control_status_page_bench import rcs_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] A_CTL = 8'h24;
    localparam logic [7:0] A_ERR = 8'h28;
    localparam logic [7:0] A_COL = 8'h2C;
    localparam logic [7:0] A_TMR = 8'h30;
    localparam logic [1:0] OK    = RCS_RESP_OKAY;
    localparam logic [1:0] DE    = RCS_RESP_DECERR;

    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, tick;
    logic        standby, sleep, cipher, flush, tstart, tstop, running, irq;
    logic [7:0]  awaddr, araddr, reload, tcount;
    logic [31:0] wdata, rdata;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    rcs_events_t ev;
    int          err_total;
    int          check_count;

    rcs_control_status_page DUT (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .events(ev), .timer_tick(tick), .timer_reload(reload),
        .standby_request(standby), .deep_sleep_request(sleep), .cipher_active(cipher),
        .queue_flush_strobe(flush), .timer_start_strobe(tstart),
        .timer_stop_strobe(tstop), .timer_running(running), .timer_irq_flag(irq),
        .timer_count(tcount)
    );

    initial begin
        aclk = 1'b0;
        forever #4 aclk = ~aclk;
    end

    // =========================================================
    // Bus tasks.
    // The response ready lines stay high for the whole run, so no
    // task ever has to lower and raise them in one time step.
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er,
                      input logic [2:0] es);
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        `CHK(bresp, er)
        // Strobes pulse in the response cycle, so they are seen at this edge.
        `CHK({tstop, tstart, flush}, es)
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        araddr  <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        if (er == OK) `CHK(rdata, {24'h0, ed})
        `CHK(rresp, er)
    endtask

    task automatic settle();
        @(posedge aclk);
        ev <= '0;
    endtask

    // =========================================================
    // Scenarios.
    task automatic t_reset_map();
        rd(A_CTL, 8'h00, OK);
        rd(A_ERR, 8'h40, OK);
        rd(A_COL, 8'h00, OK);
        rd(A_TMR, 8'h00, OK);
        rd(8'h34, 8'h00, DE);
        rd(8'h25, 8'h00, DE);
        wr(8'h34, 8'h01, DE, 3'b000);
        wr(A_ERR, 8'h00, OK, 3'b000);
        rd(A_ERR, 8'h40, OK);
    endtask

    task automatic t_control();
        wr(A_CTL, 8'h27, OK, 3'b111);
        `CHK({standby, sleep, cipher}, 3'b100)
        rd(A_CTL, 8'h20, OK);
        wr(A_CTL, 8'h10, OK, 3'b000);
        `CHK({standby, sleep}, 2'b01)
        rd(A_CTL, 8'h10, OK);
        wr(A_CTL, 8'h08, OK, 3'b000);
        `CHK(cipher, 1'b0)
        rd(A_CTL, 8'h00, OK);
        // A write without the low byte lane must leave the control bits alone.
        wstrb <= 4'hE;
        wr(A_CTL, 8'h21, OK, 3'b000);
        wstrb <= 4'hF;
        `CHK(standby, 1'b0)
    endtask

    task automatic t_cipher();
        ev.auth_second_step_done <= 1'b1;
        settle();
        rd(A_CTL, 8'h08, OK);
        `CHK(cipher, 1'b1)
        wr(A_CTL, 8'h00, OK, 3'b000);
        `CHK(cipher, 1'b0)
    endtask

    task automatic t_errors();
        ev <= '{key_format_bad: 1'b1, eeprom_rights_bad: 1'b1, queue_write_full: 1'b1,
                rx_checksum_enable: 1'b1, checksum_bad: 1'b1, start_frame_bad: 1'b1,
                parity_bad: 1'b1, collision_seen: 1'b1, collision_bit_pos: 8'h05,
                default: '0};
        settle();
        rd(A_ERR, 8'h7F, OK);
        rd(A_COL, 8'h05, OK);
        ev <= '{collision_seen: 1'b1, collision_bit_pos: 8'h08, default: '0};
        settle();
        rd(A_COL, 8'h05, OK);
        ev.receiver_prepare_state <= 1'b1;
        settle();
        rd(A_ERR, 8'h70, OK);
        ev.checksum_bad <= 1'b1;
        settle();
        rd(A_ERR, 8'h70, OK);
        ev.key_load_start <= 1'b1;
        settle();
        rd(A_ERR, 8'h30, OK);
        ev.eeprom_cmd_start <= 1'b1;
        settle();
        rd(A_ERR, 8'h10, OK);
        wr(A_CTL, 8'h01, OK, 3'b001);
        rd(A_ERR, 8'h00, OK);
        ev <= '{collision_seen: 1'b1, protocol_type_b: 1'b1, collision_bit_pos: 8'h03,
                default: '0};
        settle();
        rd(A_COL, 8'h05, OK);
        ev.receiver_prepare_state <= 1'b1;
        settle();
        ev <= '{collision_seen: 1'b1, collision_bit_pos: 8'h08, default: '0};
        settle();
        rd(A_COL, 8'h08, OK);
        rd(A_ERR, 8'h01, OK);
    endtask

    task automatic t_timer();
        reload <= 8'h03;
        wr(A_CTL, 8'h02, OK, 3'b010);
        rd(A_TMR, 8'h03, OK);
        `CHK({running, irq}, 2'b10)
        tick <= 1'b1;
        repeat (2) @(posedge aclk);
        tick <= 1'b0;
        rd(A_TMR, 8'h01, OK);
        `CHK(irq, 1'b0)
        tick <= 1'b1;
        @(posedge aclk);
        tick <= 1'b0;
        rd(A_TMR, 8'h00, OK);
        `CHK({running, irq, tcount}, 10'h100)
        reload <= 8'h05;
        wr(A_CTL, 8'h02, OK, 3'b010);
        tick <= 1'b1;
        @(posedge aclk);
        tick <= 1'b0;
        wr(A_CTL, 8'h04, OK, 3'b100);
        // The stop strobe acts on the edge at which the response is seen.
        @(posedge aclk);
        `CHK(running, 1'b0)
        tick <= 1'b1;
        repeat (2) @(posedge aclk);
        tick <= 1'b0;
        rd(A_TMR, 8'h04, OK);
    endtask

    // =========================================================
    // Verdict and run control.
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #50000;
        err_total++;
        summarize();
    end

    initial begin
        err_total   = 0;
        check_count = 0;
        aresetn     = 1'b0;
        {awvalid, wvalid, arvalid, tick} = 4'h0;
        {bready, rready} = 2'h3;
        {awaddr, araddr, reload} = 24'h0;
        wdata = 32'h0;
        wstrb = 4'hF;
        ev    = '0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset_map();
        t_control();
        t_cipher();
        t_errors();
        t_timer();
        summarize();
    end
endmodule
`undef CHK
`default_nettype wire
